/* File: rtl/cfg_seq_pkg.sv */
package cfg_seq_pkg;
	localparam int MCLK_MHZ = 250;
	localparam int INIT_MIN_US = 50;
	localparam int INIT_MAX_US = 250;
	localparam int INIT_MIN_CYC = INIT_MIN_US * MCLK_MHZ;
	localparam int INIT_MAX_CYC = INIT_MAX_US * MCLK_MHZ;
	localparam int OSC_DIV = 16;
	localparam int MODE_SETTLE_TICKS = 2;
	localparam int SLOW_HALF = 32;
	localparam int RATE_FACTOR = 8;
	localparam int FAST_HALF = SLOW_HALF / RATE_FACTOR;
	localparam int LEN_BITS = 24;
	localparam int CHECK_BITS = 4;
	localparam int SIGNAL_ACCESS_A_CLKS = 4;
	localparam int RB_SUM_BITS = 11;
	localparam logic [3:0] PREAMBLE = 4'h2;
	localparam logic [15:0] CRC16_POLY = 16'h1021;
	localparam logic [15:0] CRC16_INIT = 16'h0000;
	localparam logic [3:0] CRC4_POLY = 4'h3;
	localparam logic [3:0] CRC4_INIT = 4'h0;
	localparam logic [2:0] MODE_MSER = 3'h0;
	localparam logic [2:0] MODE_MPU = 3'h4;
	localparam logic [2:0] MODE_APER = 3'h5;
	localparam logic [2:0] MODE_MPD = 3'h6;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LENGTH = 8'h08;
	localparam logic [7:0] REG_RBSUM = 8'h0c;
	localparam int CTRL_DONE_LSB = 0;
	localparam int CTRL_GSR_LSB = 2;
	localparam int CTRL_IO_LSB = 4;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RST = 6'h2d;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_MODE_LSB = 4;
	localparam int STAT_ERR_BIT = 7;
	localparam int STAT_FAST_BIT = 8;
	localparam int STAT_MASTER_BIT = 9;

	typedef enum logic [3:0] {
		ST_CLEAR = 4'h0, ST_LASTCLR = 4'h1, ST_INITW = 4'h2,
		ST_MODES = 4'h3, ST_SETTLE = 4'h4, ST_PRE = 4'h5,
		ST_LEN = 4'h6, ST_FRAME = 4'h7, ST_POST = 4'h8,
		ST_START = 4'h9, ST_USER = 4'ha, ST_ERR = 4'hb
	} state_t;

	typedef struct packed {
		logic highDuringConfig;
		logic lowDuringConfigN;
		logic initOe;
		logic done;
	} statusPins_t;

	typedef struct packed {
		logic globalSetReset;
		logic userIoEnable;
	} signal_access_a_t;

	function automatic logic [15:0] crc16Step(logic [15:0] c, logic b);
		crc16Step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC16_POLY : 16'h0000);
	endfunction

	function automatic logic [3:0] crc4Step(logic [3:0] c, logic b);
		crc4Step = {c[2:0], 1'b0} ^ ((c[3] ^ b) ? CRC4_POLY : 4'h0);
	endfunction

	function automatic logic isMaster(logic [2:0] m);
		isMaster = m == MODE_MSER || m == MODE_MPU || m == MODE_MPD ||
			m == MODE_APER;
	endfunction
endpackage

/* File: rtl/fpga_config_sequencer.sv */
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module fpga_config_sequencer
	import cfg_seq_pkg::*;
#(
	parameter int FRAMES = 788,
	parameter int FRAME_BITS = 226,
	parameter int POR_TICKS = 64,
	parameter int RATE_POS = 2,
	parameter int INIT_MIN_CYCLES = INIT_MIN_CYC,
	parameter int INIT_MAX_CYCLES = INIT_MAX_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic programN,
	input wire logic initIn,
	input wire logic [2:0] modeIn,
	input wire logic configClockIn,
	input wire logic configDataIn,
	output logic configClockOut,
	output logic configClockOe,
	output logic configDataOut,
	output statusPins_t statusPins,
	output signal_access_a_t startupSig,
	input wire logic rbBit,
	input wire logic rbValid,
	input wire logic rbLast,
	output logic rbOut,
	output logic rbOutValid
);
	localparam int FW = $clog2(FRAMES + 1);
	localparam int BW = $clog2(FRAME_BITS + 1);
	localparam int PW = $clog2(POR_TICKS + 1);
	localparam int DW = $clog2(INIT_MAX_CYCLES + INIT_MIN_CYCLES + 1);
	localparam int OW = $clog2(OSC_DIV);
	localparam int HW = $clog2(SLOW_HALF);
	localparam logic [FW-1:0] LAST_FRAME = FW'(FRAMES - 1);
	localparam logic [BW-1:0] DATA_END = BW'(FRAME_BITS - CHECK_BITS);
	localparam logic [BW-1:0] LAST_BIT = BW'(FRAME_BITS - 1);
	localparam logic [BW-1:0] RATE_BIT = BW'(RATE_POS);
	localparam logic [PW-1:0] POR_L = PW'(POR_TICKS);
	localparam logic [DW-1:0] INIT_MIN_L = DW'(INIT_MIN_CYCLES - 1);
	localparam logic [DW-1:0] INIT_MAX_L = DW'(INIT_MAX_CYCLES - 1);
	localparam logic [DW-1:0] SETTLE_L = DW'(MODE_SETTLE_TICKS - 1);
	localparam logic [OW-1:0] OSC_L = OW'(OSC_DIV - 1);
	localparam logic [HW-1:0] SLOW_L = HW'(SLOW_HALF - 1);
	localparam logic [HW-1:0] FAST_L = HW'(FAST_HALF - 1);
	localparam logic [4:0] LEN_L = 5'(LEN_BITS - 1);
	localparam logic [2:0] STEP_L = 3'(SIGNAL_ACCESS_A_CLKS - 1);
	localparam logic [3:0] RB_L = 4'(RB_SUM_BITS - 1);

	typedef struct packed {
		state_t state;
		logic [1:0] progS;
		logic [1:0] initS;
		logic [2:0] ckS;
		logic [1:0] dinS;
		logic [2:0] modeS0;
		logic [2:0] modeS1;
		logic [OW-1:0] oscDiv;
		logic [PW-1:0] porCnt;
		logic [FW-1:0] frameCnt;
		logic [DW-1:0] dly;
		logic [2:0] mode;
		logic master;
		logic fast;
		logic [HW-1:0] ckDiv;
		logic ckOut;
		logic [3:0] pre;
		logic [LEN_BITS-1:0] len;
		logic [4:0] lenCnt;
		logic [LEN_BITS-1:0] clkCnt;
		logic inFrame;
		logic [BW-1:0] bitCnt;
		logic [3:0] crc4;
		logic [3:0] chk;
		logic [2:0] step;
		logic dout;
		logic doutPend;
		logic err;
		logic [15:0] crc16;
		logic [15:0] rbSum;
		logic [3:0] rbCnt;
		logic rbApp;
		logic rbOut;
		logic rbOutValid;
		logic [CTRL_W-1:0] ctrl;
		logic wrPend;
		logic [7:0] wrAddr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic ckOe;
		statusPins_t pins;
		signal_access_a_t su;
	} st_t;

	st_t st_q;
	st_t st_d;
	logic frameBad;

	function automatic logic evt(logic [1:0] slot, st_t s);
		evt = s.state == ST_USER || (s.state == ST_START && s.step > 3'(slot));
	endfunction

	function automatic logic [31:0] regRead(logic [7:0] a, st_t s);
		regRead = 32'h0000_0000;
		if (a == REG_CTRL) begin
			regRead[CTRL_W-1:0] = s.ctrl;
		end else if (a == REG_STATUS) begin
			regRead[STAT_STATE_LSB +: 4] = s.state;
			regRead[STAT_MODE_LSB +: 3] = s.mode;
			regRead[STAT_ERR_BIT] = s.err;
			regRead[STAT_FAST_BIT] = s.fast;
			regRead[STAT_MASTER_BIT] = s.master;
		end else if (a == REG_LENGTH) begin
			regRead[LEN_BITS-1:0] = s.len;
		end else if (a == REG_RBSUM) begin
			regRead[15:0] = s.rbSum;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic oscTick;
		logic progHigh;
		logic bitIn;
		logic rise;
		logic fall;
		logic run;
		logic toggle;
		logic addrPh;
		logic [15:0] crcN;
		logic [LEN_BITS-1:0] clkN;
		logic [HW-1:0] half;
		oscTick = 1'b0;
		progHigh = 1'b0;
		bitIn = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		run = 1'b0;
		toggle = 1'b0;
		addrPh = 1'b0;
		crcN = 16'h0000;
		clkN = '0;
		half = '0;
		st_d = st_q;
		frameBad = 1'b0;
		// input synchronisers
		st_d.progS = {st_q.progS[0], programN};
		st_d.initS = {st_q.initS[0], initIn};
		st_d.ckS = {st_q.ckS[1:0], configClockIn};
		st_d.dinS = {st_q.dinS[0], configDataIn};
		st_d.modeS0 = modeIn;
		st_d.modeS1 = st_q.modeS0;
		progHigh = st_q.progS[1];
		bitIn = st_q.dinS[1];
		// internal oscillator and power-on delay
		oscTick = st_q.oscDiv == OSC_L;
		st_d.oscDiv = oscTick ? '0 : st_q.oscDiv + 1'b1;
		if (oscTick && st_q.porCnt != POR_L) begin
			st_d.porCnt = st_q.porCnt + 1'b1;
		end
		// configuration clock: own divider or sampled input
		run = st_q.state inside {ST_PRE, ST_LEN, ST_FRAME, ST_POST, ST_START};
		if (st_q.master) begin
			half = st_q.fast ? FAST_L : SLOW_L;
			toggle = run && st_q.ckDiv == half;
			st_d.ckDiv = (toggle || !run) ? '0 : st_q.ckDiv + 1'b1;
			if (toggle) begin
				st_d.ckOut = !st_q.ckOut;
			end
			rise = toggle && !st_q.ckOut;
			fall = toggle && st_q.ckOut;
		end else begin
			rise = run && st_q.ckS[1] && !st_q.ckS[2];
			fall = run && !st_q.ckS[1] && st_q.ckS[2];
		end
		if (fall) begin
			st_d.dout = st_q.doutPend;
		end
		////////////////////////////////////////////////////////////////////
		// sequencer
		if (st_q.state == ST_CLEAR || st_q.state == ST_LASTCLR) begin
			if (oscTick) begin
				st_d.frameCnt = st_q.frameCnt + 1'b1;
				if (st_q.frameCnt == LAST_FRAME) begin
					st_d.frameCnt = '0;
					if (st_q.state == ST_LASTCLR) begin
						st_d.state = ST_INITW;
						st_d.dly = '0;
					end else if (st_q.porCnt == POR_L && progHigh) begin
						st_d.state = ST_LASTCLR;
					end
				end
			end
		end else if (st_q.state == ST_INITW) begin
			if (!st_q.initS[1]) begin
				st_d.dly = '0;
			end else if (!isMaster(st_q.modeS1) || st_q.dly == INIT_MIN_L) begin
				st_d.state = ST_MODES;
				st_d.dly = '0;
			end else begin
				st_d.dly = st_q.dly + 1'b1;
			end
		end else if (st_q.state == ST_MODES) begin
			if (oscTick) begin
				st_d.dly = st_q.dly + 1'b1;
				if (st_q.dly == SETTLE_L) begin
					st_d.mode = st_q.modeS1;
					st_d.master = isMaster(st_q.modeS1);
					st_d.state = ST_SETTLE;
					st_d.dly = '0;
				end
			end
		end else if (st_q.state == ST_SETTLE) begin
			st_d.dly = st_q.dly + 1'b1;
			if (!st_q.master || st_q.dly == INIT_MAX_L) begin
				st_d.state = ST_PRE;
				st_d.pre = 4'hf;
				st_d.clkCnt = '0;
			end
		end else if (rise) begin
			clkN = st_q.clkCnt + 1'b1;
			st_d.clkCnt = clkN;
			if (st_q.state == ST_PRE) begin
				st_d.doutPend = bitIn;
				st_d.pre = {st_q.pre[2:0], bitIn};
				if ({st_q.pre[2:0], bitIn} == PREAMBLE) begin
					st_d.state = ST_LEN;
					st_d.lenCnt = '0;
				end
			end else if (st_q.state == ST_LEN) begin
				st_d.doutPend = bitIn;
				st_d.len = {st_q.len[LEN_BITS-2:0], bitIn};
				st_d.lenCnt = st_q.lenCnt + 1'b1;
				if (st_q.lenCnt == LEN_L) begin
					st_d.state = ST_FRAME;
					st_d.frameCnt = '0;
					st_d.inFrame = 1'b0;
				end
			end else if (st_q.state == ST_FRAME) begin
				st_d.doutPend = 1'b1;
				if (!st_q.inFrame) begin
					if (!bitIn) begin
						st_d.inFrame = 1'b1;
						st_d.bitCnt = BW'(1);
						st_d.crc4 = CRC4_INIT;
					end
				end else begin
					st_d.bitCnt = st_q.bitCnt + 1'b1;
					if (st_q.bitCnt < DATA_END) begin
						st_d.crc4 = crc4Step(st_q.crc4, bitIn);
						if (st_q.frameCnt == '0 && st_q.bitCnt == RATE_BIT &&
							st_q.master && bitIn) begin
							st_d.fast = 1'b1;
						end
					end else begin
						st_d.chk = {st_q.chk[2:0], bitIn};
					end
					if (st_q.bitCnt == LAST_BIT) begin
						st_d.inFrame = 1'b0;
						st_d.frameCnt = st_q.frameCnt + 1'b1;
						if ({st_q.chk[2:0], bitIn} != st_q.crc4) begin
							frameBad = 1'b1;
							st_d.state = ST_ERR;
							st_d.err = 1'b1;
						end else if (st_q.frameCnt == LAST_FRAME) begin
							st_d.state = ST_POST;
						end
					end
				end
			end else if (st_q.state == ST_POST) begin
				st_d.doutPend = bitIn;
				if (clkN >= st_q.len) begin
					st_d.state = ST_START;
					st_d.step = '0;
				end
			end else if (st_q.state == ST_START) begin
				st_d.step = st_q.step + 1'b1;
				if (st_q.step == STEP_L) begin
					st_d.state = ST_USER;
				end
			end
		end
		if (!progHigh) begin
			if (st_q.state != ST_CLEAR) begin
				st_d.frameCnt = '0;
			end
			st_d.state = ST_CLEAR;
			st_d.err = 1'b0;
			st_d.fast = 1'b0;
			st_d.master = 1'b0;
			st_d.ckOut = 1'b0;
			st_d.inFrame = 1'b0;
			st_d.doutPend = 1'b1;
			st_d.dout = 1'b1;
		end
		////////////////////////////////////////////////////////////////////
		// readback stream with appended checksum
		st_d.rbOutValid = 1'b0;
		if (st_q.rbApp) begin
			st_d.rbOut = st_q.crc16[15];
			st_d.rbOutValid = 1'b1;
			st_d.crc16 = {st_q.crc16[14:0], 1'b0};
			st_d.rbCnt = st_q.rbCnt + 1'b1;
			if (st_q.rbCnt == RB_L) begin
				st_d.rbApp = 1'b0;
				st_d.crc16 = CRC16_INIT;
			end
		end else if (rbValid) begin
			crcN = crc16Step(st_q.crc16, rbBit);
			st_d.crc16 = crcN;
			st_d.rbOut = rbBit;
			st_d.rbOutValid = 1'b1;
			if (rbLast) begin
				st_d.rbApp = 1'b1;
				st_d.rbCnt = '0;
				st_d.rbSum = crcN;
			end
		end
		////////////////////////////////////////////////////////////////////
		// bus slave, zero wait states
		addrPh = hsel && htrans[1] && hready;
		if (st_q.wrPend && st_q.wrAddr == REG_CTRL) begin
			st_d.ctrl = hwdata[CTRL_W-1:0];
		end
		st_d.wrPend = addrPh && hwrite;
		st_d.wrAddr = haddr[7:0];
		st_d.hrdata = (addrPh && !hwrite) ? regRead(haddr[7:0], st_d) :
			32'h0000_0000;
		st_d.hreadyout = 1'b1;
		////////////////////////////////////////////////////////////////////
		// pins from next state
		st_d.pins.highDuringConfig = st_d.state != ST_USER;
		st_d.pins.lowDuringConfigN = st_d.state == ST_USER;
		st_d.pins.initOe = st_d.state inside {ST_CLEAR, ST_LASTCLR, ST_ERR} ||
			!progHigh;
		st_d.pins.done = evt(st_d.ctrl[CTRL_DONE_LSB +: 2], st_d);
		st_d.su.globalSetReset = !evt(st_d.ctrl[CTRL_GSR_LSB +: 2], st_d);
		st_d.su.userIoEnable = evt(st_d.ctrl[CTRL_IO_LSB +: 2], st_d);
		st_d.ckOe = st_d.master;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= '0;
			st_q.ctrl <= CTRL_RST;
			st_q.crc16 <= CRC16_INIT;
			st_q.dout <= 1'b1;
			st_q.doutPend <= 1'b1;
			st_q.hreadyout <= 1'b1;
			st_q.pins.highDuringConfig <= 1'b1;
			st_q.pins.initOe <= 1'b1;
			st_q.su.globalSetReset <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign hrdata = st_q.hrdata;
	assign hreadyout = st_q.hreadyout;
	assign hresp = 1'b0;
	assign configClockOut = st_q.ckOut;
	assign configClockOe = st_q.ckOe;
	assign configDataOut = st_q.dout;
	assign statusPins = st_q.pins;
	assign startupSig = st_q.su;
	assign rbOut = st_q.rbOut;
	assign rbOutValid = st_q.rbOutValid;

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	a_err_init_low: assert property (
		st_q.state == ST_ERR |-> statusPins.initOe)
		else $error("init not driven low in error wait");
	a_bad_frame_stop: assert property (
		frameBad && st_q.progS[1] |=> st_q.state == ST_ERR && st_q.err)
		else $error("bad frame did not stop loading");
	a_config_status: assert property (
		st_q.state != ST_USER |->
		statusPins.highDuringConfig && !statusPins.lowDuringConfigN)
		else $error("status pins wrong during configuration");
	a_done_held_low: assert property (
		st_q.state inside {ST_CLEAR, ST_INITW, ST_PRE, ST_FRAME, ST_ERR}
		|-> !statusPins.done)
		else $error("done high before start-up");
	a_program_init: assert property (
		!st_q.progS[1] |=> statusPins.initOe && st_q.state == ST_CLEAR)
		else $error("program low did not force init low");
	a_dout_hold_high: assert property (
		st_q.state == ST_FRAME && st_q.inFrame && st_q.bitCnt > BW'(2)
		|-> configDataOut)
		else $error("frame bits leaked downstream");
	a_mode_capture: assert property (
		st_q.state == ST_MODES && st_d.state == ST_SETTLE
		|=> st_q.mode == $past(st_q.modeS1))
		else $error("mode inputs not captured");
	a_rb_append_len: assert property (
		rbValid && rbLast && !st_q.rbApp |=>
		st_q.rbApp [*8] ##1 st_q.rbApp [*3] ##1 !st_q.rbApp)
		else $error("checksum append not eleven bits");
	a_slow_rate: assert property (
		st_q.state inside {ST_PRE, ST_LEN} |-> !st_q.fast)
		else $error("fast clock before rate bit");
	a_user_events: assert property (
		st_q.state == ST_USER |-> statusPins.done &&
		startupSig.userIoEnable && !startupSig.globalSetReset)
		else $error("start-up events incomplete in user mode");

	c_user_mode: cover property (st_q.state == ST_USER);
	c_frame_error: cover property (frameBad);
	c_readback_sum: cover property ($fell(st_q.rbApp));
	c_fast_clock: cover property ($rose(st_q.fast));
endmodule
`default_nettype wire

/* File: bench/cfg_source_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cfg_source_model (
	output logic linkClock,
	output logic linkData,
	input wire logic dataOutSeen,
	input wire logic clockSeen
);
	logic seenQ[$];
	int lowTime = 0;

	initial begin
		linkClock = 1'b0;
		linkData = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// one serial bit: data well ahead of the rise, held well after it
	task automatic sendBit(input logic b);
		#8 linkData = b;
		#24 seenQ.push_back(dataOutSeen);
		linkClock = 1'b1;
		#32 linkClock = 1'b0;
	endtask

	// master mode: next bit after each falling edge of the device clock
	task automatic sendBitM(input logic b);
		int t0;
		@(negedge clockSeen);
		t0 = int'($time);
		#1 linkData = b;
		@(posedge clockSeen);
		lowTime = int'($time) - t0;
	endtask

	// source inverts the data line once, clock stays parked low
	task automatic idleLine();
		#8 linkData = ~linkData;
	endtask
endmodule
`default_nettype wire

/* File: bench/fpga_config_sequencer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module fpga_config_sequencer_tb_top;
	import cfg_seq_pkg::*;
	localparam logic [23:0] LEN = 24'h00_0046;
	localparam logic [15:0] RB = 16'hb3c5;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic programN = 1'b1;
	logic extHold = 1'b0;
	logic [2:0] modeIn = 3'h7;
	logic rbBit = 1'b0;
	logic rbValid = 1'b0;
	logic rbLast = 1'b0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, linkClock, linkData, dOut, clkOut, clkOe;
	logic rbOut, rbOutValid, initWire;
	statusPins_t pins;
	signal_access_a_t su;
	logic q[$];
	logic rbQ[$];
	int nErrors = 0;
	int numChecks = 0;
	int cycles = 0;

	// open-drain init wire with pull-up
	assign initWire = !(pins.initOe || extHold);
	always #2 mclk = ~mclk;

	fpga_config_sequencer #(.FRAMES(3), .FRAME_BITS(12), .POR_TICKS(2),
		.RATE_POS(2), .INIT_MIN_CYCLES(20), .INIT_MAX_CYCLES(40)) i_dut (
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.programN(programN), .initIn(initWire), .modeIn(modeIn),
		.configClockIn(linkClock), .configDataIn(linkData),
		.configClockOut(clkOut), .configClockOe(clkOe),
		.configDataOut(dOut), .statusPins(pins), .startupSig(su),
		.rbBit(rbBit), .rbValid(rbValid), .rbLast(rbLast), .rbOut(rbOut),
		.rbOutValid(rbOutValid));

	cfg_source_model i_src (.linkClock(linkClock), .linkData(linkData),
		.dataOutSeen(dOut), .clockSeen(clkOut));

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (rbOutValid === 1'b1) begin
			rbQ.push_back(rbOut);
		end
		if (cycles == 60000) begin
			nErrors++;
			endSim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nErrors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic endSim();
		$display("checks=%0d errors=%0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic ahbXfer(input logic [7:0] a, input logic wr,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask

	task automatic regCheck(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahbXfer(a, 1'b0, 32'h0000_0000, d);
		check(d, exp);
	endtask

	task automatic waitState(input logic [3:0] s);
		logic [31:0] d;
		d = 32'hffff_ffff;
		for (int i = 0; i < 3000 && d[3:0] !== s; i++) begin
			ahbXfer(REG_STATUS, 1'b0, 32'h0000_0000, d);
		end
	endtask

	function automatic logic [3:0] chk4(input logic [6:0] d);
		logic [3:0] c;
		c = 4'h0;
		for (int i = 6; i >= 0; i--) begin
			c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? CRC4_POLY : 4'h0);
		end
		return c;
	endfunction

	// ones, preamble, length, three frames, postamble 0101
	task automatic sendStream(input logic bad, input logic master);
		logic [6:0] d;
		logic [3:0] c;
		q.delete();
		q = {1'b1, 1'b1};
		for (int i = 3; i >= 0; i--) q.push_back(PREAMBLE[i]);
		for (int i = 23; i >= 0; i--) q.push_back(LEN[i]);
		for (int f = 0; f < 3; f++) begin
			// frame 0 carries the rate bit; slaves ignore it
			d = 7'(f * 37 + 11) | ((f == 0) ? 7'h20 : 7'h00);
			c = chk4(d) ^ ((bad && f == 1) ? 4'h1 : 4'h0);
			q.push_back(1'b0);
			for (int i = 6; i >= 0; i--) q.push_back(d[i]);
			for (int i = 3; i >= 0; i--) q.push_back(c[i]);
		end
		q = {q, 1'b0, 1'b1, 1'b0, 1'b1};
		i_src.seenQ.delete();
		#1;
		foreach (q[i]) begin
			if (master) begin
				i_src.sendBitM(q[i]);
				if (i == 3) check(32'(i_src.lowTime), 32'(SLOW_HALF * 4));
				if (i == 60) check(32'(i_src.lowTime), 32'(FAST_HALF * 4));
			end else begin
				i_src.sendBit(q[i]);
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic runGood();
		logic [31:0] d;
		check(32'(pins), 32'h0000_000a);
		check(32'(su), 32'h0000_0002);
		regCheck(REG_CTRL, 32'h0000_002d);
		ahbXfer(REG_CTRL, 1'b1, 32'h0000_0006, d);
		ahbXfer(8'h10, 1'b1, 32'hffff_ffff, d);
		regCheck(REG_CTRL, 32'h0000_0006);
		regCheck(8'h10, 32'h0000_0000);
		waitState(4'h5);
		regCheck(REG_STATUS, 32'h0000_0075);
		check(32'(pins), 32'h0000_0008);
		check(32'(clkOe), 32'h0000_0000);
		sendStream(1'b0, 1'b0);
		for (int k = 1; k < 70; k++) begin
			if (k > 30 && k < 67) begin
				check(32'(i_src.seenQ[k]), 32'h0000_0001);
			end else begin
				check(32'(i_src.seenQ[k]), 32'(q[k - 1]));
			end
		end
		regCheck(REG_LENGTH, {8'h00, LEN});
		check(32'(pins), 32'h0000_0008);
		// io, then set/reset release, then done
		for (int r = 1; r <= 4; r++) begin
			i_src.sendBit(1'b1);
			check(32'({pins.done, su}), 32'({r >= 3, r < 2, r >= 1}));
		end
		i_src.idleLine();
		regCheck(REG_STATUS, 32'h0000_007a);
		check(32'(pins), 32'h0000_0005);
	endtask

	// readback words here hold no state-dependent outputs
	task automatic readBack();
		logic [15:0] crc;
		logic [26:0] got;
		crc = 16'h0000;
		got = 27'h000_0000;
		rbQ.delete();
		for (int i = 15; i >= 0; i--) begin
			@(posedge mclk);
			rbBit <= RB[i];
			rbValid <= 1'b1;
			rbLast <= (i == 0);
			crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ RB[i]) ? CRC16_POLY : 16'h0000);
		end
		@(posedge mclk);
		rbValid <= 1'b0;
		rbLast <= 1'b0;
		repeat (16) @(posedge mclk);
		foreach (rbQ[i]) got = {got[25:0], rbQ[i]};
		check(32'(rbQ.size()), 32'h0000_001b);
		check(32'(got), {5'h00, RB, crc[15:5]});
		regCheck(REG_RBSUM, {16'h0000, crc});
	endtask

	task automatic progAndError();
		logic [31:0] d;
		@(posedge mclk);
		programN <= 1'b0;
		repeat (40) @(posedge mclk);
		check(32'(pins), 32'h0000_000a);
		ahbXfer(REG_STATUS, 1'b0, 32'h0000_0000, d);
		check(32'(d[3:0]), 32'h0000_0000);
		extHold <= 1'b1;
		programN <= 1'b1;
		waitState(4'h2);
		repeat (200) @(posedge mclk);
		regCheck(REG_STATUS, 32'h0000_0072);
		check(32'(pins), 32'h0000_0008);
		extHold <= 1'b0;
		waitState(4'h5);
		regCheck(REG_STATUS, 32'h0000_0075);
		sendStream(1'b1, 1'b0);
		i_src.idleLine();
		regCheck(REG_STATUS, 32'h0000_00fb);
		check(32'(pins), 32'h0000_000a);
	endtask

	// master serial: own clock, slow until the rate bit, then fast
	task automatic masterRun();
		@(posedge mclk);
		programN <= 1'b0;
		modeIn <= MODE_MSER;
		repeat (40) @(posedge mclk);
		programN <= 1'b1;
		waitState(4'h5);
		regCheck(REG_STATUS, 32'h0000_0205);
		check(32'(clkOe), 32'h0000_0001);
		sendStream(1'b0, 1'b1);
		waitState(4'ha);
		regCheck(REG_STATUS, 32'h0000_030a);
		check(32'(pins), 32'h0000_0005);
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		runGood();
		readBack();
		progAndError();
		masterRun();
		endSim();
	end
endmodule
`default_nettype wire
